// File: rtl/io_channel_parity_and_status.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module io_channel_parity_and_status
  import chan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Step sequencer and internal bus
  input wire step_e step,
  input wire logic phase_c6,
  input wire logic byte_done,
  input wire logic [BUS_W-1:0] bus_data,
  input wire logic op_is_sense,
  input wire logic op_is_write,
  input wire logic end_present,
  input wire logic control_word_read,
  input wire logic main_memory_parity_error,
  input wire logic scratch_pad_error,
  input wire logic addr_beyond_max,
  input wire logic [KEY_W-1:0] proc_key,
  input wire logic [KEY_W-1:0] mem_key,
  input wire logic count_nonzero,
  input wire logic chain_data_flag,
  input wire logic suppress_length_flag,
  input wire logic load_active,
  input wire logic burst_mode,
  input wire logic catch_up_mode,
  input wire logic switch_end_condition,
  input wire logic set_interrupt_request,
  // Peripheral trunk receivers
  input wire logic [CHAR_W-1:0] input_data_lines,
  // Results
  output logic input_parity_error,
  output logic io_error_signal,
  output logic error_stop_flop,
  output logic run_clear,
  output logic [CHAR_W-1:0] inbound_byte_lines,
  output logic [CHAR_W-1:0] output_byte_register,
  output logic terminate_any,
  output logic terminate_strobe,
  output logic set_interrupt_strobe,
  output logic burst_break,
  output logic store_status_select,
  output logic status_write,
  output logic [CSR_W-1:0] status_byte
);

  function automatic logic keys_accept(input logic [KEY_W-1:0] a, input logic [KEY_W-1:0] b);
    keys_accept = (a == b) || (a == KEY_ZERO) || (b == KEY_ZERO);
  endfunction

  function automatic logic misaligned(input logic [BUS_W-1:0] w);
    misaligned = (w[BUS_ALIGN_MSB:0] != ALIGN_ZERO);
  endfunction

  logic [CHAR_W-1:0] din_meta_q;
  logic [CHAR_W-1:0] din_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic parity_err_q;
  logic error_stop_q;
  logic deferred_q;
  logic [CSR_W-1:0] csr_q;
  logic prog_check_q;
  logic ctrl_check_q;
  logic prot_check_q;
  logic incl_length_q;
  logic data_check_q;
  logic prog_intr_q;
  logic termination_q;
  logic [CSR_W-1:0] csr_set;
  logic [CSR_W-1:0] csr_base;
  logic error_ignore_setting;
  logic error_stop_switch;
  logic protect_installed;
  logic parity_event;
  logic fetch_step;
  logic wr_ctrl;
  logic wr_flags;
  logic deferred_cause;

  parity_if pif ();

  parity_unit u_parity (
    .pif(pif)
  );

  assign error_ignore_setting = ctrl_q[CTRL_ERR_IGNORE];
  assign error_stop_switch = ctrl_q[CTRL_ERR_STOP];
  assign protect_installed = ctrl_q[CTRL_PROTECT];
  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign wr_flags = reg_wr && (reg_addr == REG_FLAGS);
  assign fetch_step = (step == STEP_FETCH_SECOND_COMMAND_WORD) || (step == STEP_FETCH_SECOND_COMMAND_WORD_BURST);

  // Trunk lines come from another box; two flops before any use
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      din_meta_q <= '0;
      din_q <= '0;
    end else begin
      din_meta_q <= input_data_lines;
      din_q <= din_meta_q;
    end
  end

  assign pif.in_char = din_q;
  assign pif.out_byte = bus_data[BYTE_W-1:0];

  assign input_parity_error = pif.in_even;

  assign parity_event = (step == STEP_READ_MOVE) && !op_is_sense && input_parity_error;

  // Indicator stays lit until software clears it; a new error wins over the clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      parity_err_q <= 1'b0;
    end else if (parity_event) begin
      parity_err_q <= 1'b1;
    end else if (wr_flags && reg_wdata[FLG_PARITY]) begin
      parity_err_q <= 1'b0;
    end
  end

  assign io_error_signal = parity_err_q && !error_ignore_setting;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      error_stop_q <= 1'b0;
    end else if (io_error_signal && error_stop_switch) begin
      error_stop_q <= 1'b1;
    end else if (wr_flags && reg_wdata[FLG_ERR_STOP]) begin
      error_stop_q <= 1'b0;
    end
  end

  assign error_stop_flop = error_stop_q;
  assign run_clear = error_stop_q && phase_c6;

  // Inbound lines are registered so the bus sees a clean byte
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      inbound_byte_lines <= '0;
    end else if (io_error_signal) begin
      inbound_byte_lines <= {din_q[PARITY_BIT], ERROR_MARK_BYTE};
    end else begin
      inbound_byte_lines <= din_q;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      output_byte_register <= '0;
    end else if (step == STEP_WRITE_MOVE) begin
      output_byte_register <= {pif.gen_bit, bus_data[BYTE_W-1:0]};
    end
  end

  // Set terms for each status flop
  always_comb begin
    csr_set = '0;
    csr_set[CSR_TERMINATION] = set_interrupt_request || set_interrupt_strobe;
    csr_set[CSR_PROG_INTR] = fetch_step && bus_data[BUS_PCI_FLAG] && !end_present;
    csr_set[CSR_DATA_CHECK] = (parity_event && !error_ignore_setting)
      || (main_memory_parity_error && ((step == STEP_READ_MOVE) || (step == STEP_WRITE_MOVE)));
    csr_set[CSR_INCL_LENGTH] = end_present && (count_nonzero || chain_data_flag)
      && !suppress_length_flag && !load_active
      && (((step == STEP_FETCH_SECOND_COMMAND_WORD) && !burst_mode && !catch_up_mode)
      || ((step == STEP_FETCH_SECOND_COMMAND_WORD_BURST) && !switch_end_condition));
    csr_set[CSR_PROT_CHECK] = (step == STEP_ADDR_MOVE) && protect_installed
      && !keys_accept(proc_key, mem_key);
    csr_set[CSR_CTRL_CHECK] = control_word_read && (scratch_pad_error || main_memory_parity_error);
    csr_set[CSR_PROG_CHECK] = (addr_beyond_max && ((step == STEP_ADDR_MOVE) || (step == STEP_ADDR_CCW)))
      || (((step == STEP_CAR_STORE) || (step == STEP_TIC_ADDR)) && misaligned(bus_data));
  end

  assign csr_base = fetch_step ? bus_data[BUS_STATUS_LSB +: CSR_W] : csr_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prog_check_q <= CSR_RESET[CSR_PROG_CHECK];
    end else begin
      prog_check_q <= csr_base[CSR_PROG_CHECK] || csr_set[CSR_PROG_CHECK];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_check_q <= CSR_RESET[CSR_CTRL_CHECK];
    end else begin
      ctrl_check_q <= csr_base[CSR_CTRL_CHECK] || csr_set[CSR_CTRL_CHECK];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prot_check_q <= CSR_RESET[CSR_PROT_CHECK];
    end else begin
      prot_check_q <= csr_base[CSR_PROT_CHECK] || csr_set[CSR_PROT_CHECK];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      incl_length_q <= CSR_RESET[CSR_INCL_LENGTH];
    end else begin
      incl_length_q <= csr_base[CSR_INCL_LENGTH] || csr_set[CSR_INCL_LENGTH];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_check_q <= CSR_RESET[CSR_DATA_CHECK];
    end else begin
      data_check_q <= csr_base[CSR_DATA_CHECK] || csr_set[CSR_DATA_CHECK];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prog_intr_q <= CSR_RESET[CSR_PROG_INTR];
    end else begin
      prog_intr_q <= csr_base[CSR_PROG_INTR] || csr_set[CSR_PROG_INTR];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      termination_q <= CSR_RESET[CSR_TERMINATION];
    end else begin
      termination_q <= csr_base[CSR_TERMINATION] || csr_set[CSR_TERMINATION];
    end
  end

  assign csr_q = {termination_q, prog_intr_q, data_check_q, incl_length_q, prot_check_q, ctrl_check_q,
    prog_check_q};

  assign terminate_any = csr_q[CSR_PROT_CHECK] || csr_q[CSR_PROG_CHECK] || csr_q[CSR_CTRL_CHECK]
    || (csr_q[CSR_DATA_CHECK] && (op_is_write || end_present))
    || (end_present && csr_q[CSR_INCL_LENGTH]);

  assign terminate_strobe = terminate_any
    && ((step == STEP_READ_MOVE) || (step == STEP_STATUS_EXIT) || (step == STEP_CAR_STORE));

  assign set_interrupt_strobe = (step == STEP_CHAIN_INTERRUPT) && !switch_end_condition && terminate_any;

  // leave burst loop for normal exit
  assign burst_break = terminate_any && (burst_mode || catch_up_mode);

  assign deferred_cause = ((step == STEP_STORE_STATUS) || (step == STEP_STORE_A_LATE))
    && (scratch_pad_error || addr_beyond_max);

  // A bit raised too late for the store-status step forces one more pass
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      deferred_q <= 1'b0;
    end else if (deferred_cause) begin
      deferred_q <= 1'b1;
    end else if ((step == STEP_STORE_STATUS) || (wr_flags && reg_wdata[FLG_DEFERRED])) begin
      deferred_q <= 1'b0;
    end
  end

  assign store_status_select = deferred_q;

  // Write-back carries late set terms too, so nothing set this cycle is lost
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_write <= 1'b0;
      status_byte <= CSR_RESET;
    end else begin
      status_write <= byte_done || (step == STEP_STORE_STATUS);
      status_byte <= csr_q | csr_set;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[CTRL_W-1:0];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
        REG_STATUS: reg_rdata <= {{(DATA_W-CSR_W){1'b0}}, csr_q};
        REG_FLAGS: reg_rdata <= {{(DATA_W-FLG_W){1'b0}}, terminate_any, deferred_q, error_stop_q, parity_err_q};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // io_channel_parity_and_status

// File: rtl/chan_pkg.sv
package chan_pkg;

  // Servicing steps announced by the step sequencer
  typedef enum logic [3:0] {
    STEP_IDLE,
    STEP_READ_MOVE,
    STEP_WRITE_MOVE,
    STEP_ADDR_MOVE,
    STEP_ADDR_CCW,
    STEP_FETCH_SECOND_COMMAND_WORD,
    STEP_FETCH_SECOND_COMMAND_WORD_BURST,
    STEP_CAR_STORE,
    STEP_TIC_ADDR,
    STEP_STATUS_EXIT,
    STEP_STORE_STATUS,
    STEP_STORE_A_LATE,
    STEP_CHAIN_INTERRUPT
  } step_e;

  localparam int BYTE_W = 8;
  localparam int CHAR_W = 9;
  localparam int BUS_W = 32;
  localparam int CSR_W = 7;
  localparam int KEY_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Channel status register bit positions
  localparam int CSR_PROG_CHECK = 0;
  localparam int CSR_CTRL_CHECK = 1;
  localparam int CSR_PROT_CHECK = 2;
  localparam int CSR_INCL_LENGTH = 3;
  localparam int CSR_DATA_CHECK = 4;
  localparam int CSR_PROG_INTR = 5;
  localparam int CSR_TERMINATION = 6;

  // Fields of the internal bus word, and the parity bit position of a nine-bit character
  localparam int BUS_STATUS_LSB = 16;
  localparam int BUS_PCI_FLAG = 27;
  localparam int BUS_ALIGN_MSB = 2;
  localparam int PARITY_BIT = 8;

  localparam logic [BYTE_W-1:0] ERROR_MARK_BYTE = 8'hff;
  localparam logic [CSR_W-1:0] CSR_RESET = 7'h00;
  localparam logic [KEY_W-1:0] KEY_ZERO = 4'h0;
  localparam logic [BUS_ALIGN_MSB:0] ALIGN_ZERO = 3'h0;

  // Register map, word addresses of the plain register port
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 4'h2;

  // Control register fields
  localparam int CTRL_ERR_IGNORE = 0;
  localparam int CTRL_ERR_STOP = 1;
  localparam int CTRL_PROTECT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // Flag register fields; the low three clear on a written one
  localparam int FLG_PARITY = 0;
  localparam int FLG_ERR_STOP = 1;
  localparam int FLG_DEFERRED = 2;
  localparam int FLG_TERM_ANY = 3;
  localparam int FLG_W = 4;

endpackage

// File: rtl/parity_if.sv
`timescale 1ns/1ps
interface parity_if;
  import chan_pkg::*;
  logic [BYTE_W-1:0] out_byte;
  logic [CHAR_W-1:0] in_char;
  logic gen_bit;
  logic in_even;

  modport user (output out_byte, output in_char, input gen_bit, input in_even);
  modport unit (input out_byte, input in_char, output gen_bit, output in_even);
endinterface

// File: rtl/parity_unit.sv
`timescale 1ns/1ps
module parity_unit
  import chan_pkg::*;
(
  parity_if.unit pif
);

  // Odd parity: the ninth bit is one when the byte carries an even count
  assign pif.gen_bit = ~(^pif.out_byte);

  // Byte plus its parity bit must hold an odd count of ones
  assign pif.in_even = ~(^pif.in_char);

endmodule // parity_unit

// File: verif/chan_assertions.sv
`timescale 1ns/1ps
module chan_assertions
  import chan_pkg::*;
(
  input logic sys_clk,
  input logic nrst,
  input step_e step,
  input logic phase_c6,
  input logic byte_done,
  input logic [BUS_W-1:0] bus_data,
  input logic switch_end_condition,
  input logic [CHAR_W-1:0] input_data_lines,
  input logic input_parity_error,
  input logic io_error_signal,
  input logic error_stop_flop,
  input logic run_clear,
  input logic [CHAR_W-1:0] inbound_byte_lines,
  input logic [CHAR_W-1:0] output_byte_register,
  input logic terminate_any,
  input logic terminate_strobe,
  input logic set_interrupt_strobe,
  input logic status_write,
  input logic [CSR_W-1:0] status_byte
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Two synchroniser stages must have left reset before the flag is judged
  chk_parity_flag: assert property ($past(nrst, 2) |-> input_parity_error == ~^$past(input_data_lines, 2))
    else $error("inbound parity flag wrong");
  chk_error_mark: assert property (io_error_signal |=> inbound_byte_lines[BYTE_W-1:0] == ERROR_MARK_BYTE)
    else $error("error marker missing");
  chk_out_parity: assert property (step == STEP_WRITE_MOVE |=>
    output_byte_register == {~^$past(bus_data[BYTE_W-1:0]), $past(bus_data[BYTE_W-1:0])})
    else $error("outbound parity wrong");
  chk_run_clear: assert property (run_clear == (error_stop_flop && phase_c6))
    else $error("run clear wrong");
  chk_set_intr: assert property (step == STEP_CHAIN_INTERRUPT && !switch_end_condition && terminate_any
    |-> set_interrupt_strobe) else $error("set interrupt not strobed");
  chk_term_strobe: assert property (terminate_any &&
    (step inside {STEP_READ_MOVE, STEP_STATUS_EXIT, STEP_CAR_STORE}) |-> terminate_strobe)
    else $error("terminate not strobed");
  chk_term_any: assert property (status_write && (|status_byte[2:0]) &&
    !($past(step) inside {STEP_FETCH_SECOND_COMMAND_WORD, STEP_FETCH_SECOND_COMMAND_WORD_BURST}) |-> terminate_any)
    else $error("terminate any missing");
  chk_status_pulse: assert property (byte_done |=> status_write)
    else $error("status write-back missing");
  cover property (set_interrupt_strobe);
  cover property (run_clear);
  cover property (status_write && status_byte[CSR_DATA_CHECK]);
endmodule // chan_assertions

bind io_channel_parity_and_status chan_assertions chk (.*);

// File: verif/trunk_model.sv
`timescale 1ns/1ps
module trunk_model
  import chan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic terminate_strobe,
  output logic [CHAR_W-1:0] lines
);
  int term_seen = 0;
  initial lines = '0;
  always @(posedge sys_clk) begin
    if (terminate_strobe) begin
      term_seen++;
    end
  end
  // Odd parity on the wire; a corrupt character flips only the parity bit
  task automatic send(input logic [BYTE_W-1:0] b, input logic bad);
    @(posedge sys_clk);
    lines <= {~^b ^ bad, b};
  endtask
endmodule // trunk_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import chan_pkg::*;
  logic sys_clk, nrst, reg_wr, reg_rd, phase_c6, byte_done, op_is_sense, op_is_write, end_present, control_word_read;
  logic main_memory_parity_error, scratch_pad_error, addr_beyond_max, count_nonzero, chain_data_flag, load_active;
  logic suppress_length_flag, burst_mode, catch_up_mode, switch_end_condition, set_interrupt_request, status_write;
  logic input_parity_error, io_error_signal, error_stop_flop, run_clear, terminate_any, terminate_strobe;
  logic set_interrupt_strobe, burst_break, store_status_select;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, bus_data, r, d;
  logic [KEY_W-1:0] proc_key, mem_key;
  logic [CHAR_W-1:0] input_data_lines, inbound_byte_lines, output_byte_register;
  logic [CSR_W-1:0] status_byte;
  step_e step;
  int num_errors = 0, check_count = 0, dc = 0, cv, io;
  logic [31:0] seed = 32'h13;

  io_channel_parity_and_status dut (.*);
  trunk_model peer (.sys_clk, .terminate_strobe, .lines(input_data_lines));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic drive(input logic [31:0] v);
    {op_is_sense, op_is_write, end_present, control_word_read, main_memory_parity_error, scratch_pad_error,
      addr_beyond_max, count_nonzero, chain_data_flag, suppress_length_flag, load_active, burst_mode, catch_up_mode,
      switch_end_condition, set_interrupt_request, byte_done, phase_c6, proc_key, mem_key} <= v[24:0];
    step <= step_e'((v[28:25] > 4'hc) ? 4'h0 : v[28:25]);
    bus_data <= {v[7:0], v[31:8]};
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Trailing idle cycle keeps two writes from lowering and raising the strobe at one edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    num_errors++;
    summarize();
  end

  initial begin
    nrst = 1'b0;
    drive(32'h0);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= '0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int a = 0; a < 4; a++) begin
      rd(4'(a));
      cmp("reset_reg", 0, d);
    end
    wr(4'h3, 32'hffff_ffff);
    rd(4'h3);
    cmp("unmapped", 0, d);
    step <= STEP_WRITE_MOVE;
    for (int i = 0; i < 8; i++) begin
      r = (i < 2) ? {32{i[0]}} : xs();
      bus_data <= r;
      @(posedge sys_clk);
      #1;
      cmp("out_byte", {~^r[7:0], r[7:0]}, output_byte_register);
    end
    step <= STEP_IDLE;
    peer.send(8'h5a, 1'b1);
    // ignore, sense, stop off, stop on
    for (int m = 0; m < 4; m++) begin
      cv = (m == 0) ? 1 : (m == 3) ? 2 : 0;
      @(posedge sys_clk);
      wr(REG_CTRL, cv);
      wr(REG_FLAGS, 32'h7);
      op_is_sense <= (m == 1);
      step <= STEP_READ_MOVE;
      @(posedge sys_clk);
      step <= STEP_IDLE;
      repeat (3) @(posedge sys_clk);
      #1;
      io = (m != 1) && (cv != 1);
      dc = dc | io;
      cmp("io_error", io, io_error_signal);
      cmp("in_mark", io ? 8'hff : 8'h5a, inbound_byte_lines[7:0]);
      rd(REG_FLAGS);
      cmp("flags", {io && cv == 2, m != 1}, d);
      phase_c6 <= 1'b1;
      byte_done <= 1'b1;
      @(posedge sys_clk);
      #1;
      cmp("run_clear", io && cv == 2, run_clear);
      cmp("data_check", dc, status_byte[CSR_DATA_CHECK]);
      @(posedge sys_clk);
      byte_done <= 1'b0;
      phase_c6 <= 1'b0;
    end
    // status char and interrupt flag from the bus
    @(posedge sys_clk);
    step <= STEP_FETCH_SECOND_COMMAND_WORD;
    bus_data <= 32'h0801_0000;
    @(posedge sys_clk);
    switch_end_condition <= 1'b1;
    step <= STEP_CHAIN_INTERRUPT;
    #1;
    cmp("term_any", 1, terminate_any);
    cmp("set_intr_se", 0, set_interrupt_strobe);
    @(posedge sys_clk);
    switch_end_condition <= 1'b0;
    #1;
    cmp("set_intr", 1, set_interrupt_strobe);
    @(posedge sys_clk);
    step <= STEP_STATUS_EXIT;
    #1;
    cmp("term_strobe", 1, terminate_strobe);
    @(posedge sys_clk);
    step <= STEP_IDLE;
    rd(REG_STATUS);
    cmp("status", 32'h61, d);
    cmp("term_seen", 1, peer.term_seen > 0);
    burst_mode <= 1'b1;
    step <= STEP_STORE_A_LATE;
    scratch_pad_error <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp("burst_break", 1, burst_break);
    cmp("deferred_set", 1, store_status_select);
    @(posedge sys_clk);
    step <= STEP_STORE_STATUS;
    scratch_pad_error <= 1'b0;
    burst_mode <= 1'b0;
    @(posedge sys_clk);
    #1;
    cmp("deferred_clr", 0, store_status_select);
    cmp("burst_idle", 0, burst_break);
    cmp("store_write", 1, status_write);
    cmp("store_byte", 32'h61, status_byte);
    @(posedge sys_clk);
    step <= STEP_IDLE;
    // Random values on every sequencer input, judged by the checker
    repeat (60) begin
      drive(xs());
      @(posedge sys_clk);
    end
    summarize();
  end
endmodule // tb_top
